// ### shared/fault_status_params.svh
`ifndef FAULT_STATUS_PARAMS_SVH
`define FAULT_STATUS_PARAMS_SVH

// Word offsets of the register window (byte addresses).
`define OFS_COMBINED_FLAGS 8'h00
`define OFS_HARD_FLAGS 8'h04
`define OFS_MEM_ADDR 8'h08
`define OFS_BUS_ADDR 8'h0c
`define OFS_CONFIG_CTRL 8'h10
`define OFS_PENDING 8'h14

// Field positions inside the combined word.
`define POS_MEM_VALID 7
`define POS_FETCH_ERR 8
`define POS_PRECISE_ERR 9
`define POS_IMPRECISE_ERR 10
`define POS_BUS_VALID 15
`define POS_UNDECODABLE 16
`define POS_BAD_STATE 17
`define POS_BAD_RETURN 18
`define POS_COPROC 19
`define POS_MISALIGN 24
`define POS_ZERO_DIV 25

// Hard fault fields.
`define POS_VECTOR_ERR 1
`define POS_FORCED 30
`define POS_DEBUG_RSVD 31

// Control register fields.
`define POS_MISALIGN_TRAP 3
`define POS_ZERO_DIV_TRAP 4

// Implemented bits of the two flag words and the control register; the rest read as zero.
`define MASK_COMBINED 32'h030f_8780
`define MASK_HARD 32'hc000_0002
`define MASK_CONFIG 32'h0000_0018

// Reset values.
`define RST_FLAGS 32'h0000_0000
`define RST_ADDR 32'h0000_0000
`define RST_CONFIG 32'h0000_0000

`endif

// ### shared/fault_status_pkg.sv
package fault_status_pkg;

    // One cycle's worth of fault events from the core.
    typedef struct packed {
        logic imprecise_data;
        logic precise_data;
        logic fetch_error;
        logic fetch_issued;
        logic zero_divide;
        logic misalign;
        logic misalign_forced;
        logic coproc;
        logic bad_return;
        logic bad_state;
        logic undecodable;
        logic forced_hard;
        logic vector_read;
        logic mem_fault;
        logic [31:0] data_addr;
        logic [31:0] mem_addr;
    } fault_event_type;

    // Register bus request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } reg_req_type;

endpackage : fault_status_pkg

// ### core/fault_status_capture.sv
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fault_status_params.svh"
// ===========================================================================
// Overview of operation
// - Imprecise data bus error sets bus bit 2, bus address untouched.
// - Imprecise bus fault stays pending until priority drops below bus fault.
// - Precise fault before imprecise handler entry keeps both flags visible.
// - Precise data error sets bus bit 1 and captures faulting address.
// - Fetch error latched at prefetch, flagged only when issued, no address.
// - All flags sticky; cleared only by writing one or reset, bus address valid also by a memory fault.
// - Divide by zero sets usage bit 9 when zero divide trap enabled.
// - Unaligned access sets usage bit 8 when misalign trap enabled.
// - Unaligned multiple or doubleword transfers always set usage bit 8.
// - Any coprocessor access sets usage bit 3.
// - Illegal exception return load sets usage bit 2.
// - Illegal execution state use sets usage bit 1, not for undefined ops.
// - Undecodable instruction sets usage bit 0.
// - Hard fault flags read normally; writing one clears, zero keeps.
// - Escalated configurable fault sets hard fault bit 30.
// - Vector read bus error sets hard fault bit 1.
// - Memory fault address holds actual faulting split-access address.
// - Bus fault address holds the address the instruction requested.
// - Bus address valid set on addressed bus fault, cleared by a memory fault.
// - Memory address valid flag shows memory fault address validity.
// ===========================================================================
module fault_status_capture
    import fault_status_pkg::*;
(
    // Clock and reset.
    input wire logic MCLK,
    input wire logic SRST,
    // Fault events from the core, same clock domain.
    input wire fault_event_type FAULT_EVENT,
    input wire logic [7:0] EXEC_PRIORITY,
    input wire logic [7:0] BUS_FAULT_PRIORITY,
    input wire logic BUS_FAULT_TAKEN,
    // Register port.
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Status towards the exception logic.
    output logic BUS_FAULT_ACTIVATE,
    output logic ZERO_DIVIDE_TRAP_EN,
    output logic MISALIGN_TRAP_EN
);

    // =======================================================================
    // State
    // =======================================================================
    logic [31:0] combined_fault_flags;
    logic [31:0] hard_fault_flags;
    logic [31:0] memory_fault_address;
    logic [31:0] bus_fault_address;
    logic [31:0] config_control_reg;
    logic fetch_error_held;
    logic imprecise_pending;
    logic [31:0] next_combined;
    logic [31:0] next_hard;

    reg_req_type req;
    fault_event_type ev;

    assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};
    assign ev = FAULT_EVENT;

    // Address decode for the write path; the read path decodes in its own case.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    wire wr_combined = req.wr && hit(req.addr, `OFS_COMBINED_FLAGS);
    wire wr_hard = req.wr && hit(req.addr, `OFS_HARD_FLAGS);
    wire wr_mem_addr = req.wr && hit(req.addr, `OFS_MEM_ADDR);
    wire wr_bus_addr = req.wr && hit(req.addr, `OFS_BUS_ADDR);
    wire wr_config = req.wr && hit(req.addr, `OFS_CONFIG_CTRL);

    // =======================================================================
    // Event decode
    // =======================================================================
    wire zero_div_trap = config_control_reg[`POS_ZERO_DIV_TRAP];
    wire misalign_trap = config_control_reg[`POS_MISALIGN_TRAP];
    wire set_zero_div = ev.zero_divide && zero_div_trap;
    // Multiple and doubleword transfers fault whatever the trap enable.
    wire set_misalign = (ev.misalign && misalign_trap) || ev.misalign_forced;
    // A fetch error stays latent until the faulting instruction issues.
    wire set_fetch = (fetch_error_held || ev.fetch_error) && ev.fetch_issued;
    // An undefined instruction that touches state reports only as undefined.
    wire set_bad_state = ev.bad_state && !ev.undecodable;

    // Set masks for each word; set is applied after clear so set wins.
    logic [31:0] set_combined;
    logic [31:0] set_hard;
    always_comb begin
        set_combined = 32'h0000_0000;
        set_combined[`POS_MEM_VALID] = ev.mem_fault;
        set_combined[`POS_FETCH_ERR] = set_fetch;
        set_combined[`POS_PRECISE_ERR] = ev.precise_data;
        set_combined[`POS_IMPRECISE_ERR] = ev.imprecise_data;
        set_combined[`POS_BUS_VALID] = ev.precise_data;
        set_combined[`POS_UNDECODABLE] = ev.undecodable;
        set_combined[`POS_BAD_STATE] = set_bad_state;
        set_combined[`POS_BAD_RETURN] = ev.bad_return;
        set_combined[`POS_COPROC] = ev.coproc;
        set_combined[`POS_MISALIGN] = set_misalign;
        set_combined[`POS_ZERO_DIV] = set_zero_div;
        set_hard = 32'h0000_0000;
        set_hard[`POS_FORCED] = ev.forced_hard;
        set_hard[`POS_VECTOR_ERR] = ev.vector_read;
    end

    // Write one to clear; reserved bits never change. A later memory fault
    // clears the bus address valid flag unless a new addressed bus fault lands.
    logic [31:0] clr_combined;
    always_comb begin
        clr_combined = wr_combined ? req.wdata : 32'h0000_0000;
        clr_combined[`POS_BUS_VALID] = clr_combined[`POS_BUS_VALID] || ev.mem_fault;
        next_combined = ((combined_fault_flags & ~clr_combined) | set_combined)
                        & `MASK_COMBINED;
        next_hard = ((hard_fault_flags & ~(wr_hard ? req.wdata : 32'h0000_0000))
                    | set_hard) & `MASK_HARD;
        // Bit 31 is reserved for debug and never set here; software's duty
        // to write one there only avoids undefined debug behaviour.
    end

    // =======================================================================
    // Flag registers
    // =======================================================================
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            combined_fault_flags <= `RST_FLAGS;
            hard_fault_flags <= `RST_FLAGS;
        end else begin
            combined_fault_flags <= next_combined;
            hard_fault_flags <= next_hard;
        end
    end

    // Prefetch bus error held until the instruction issues or reset.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            fetch_error_held <= 1'b0;
        end else if (ev.fetch_issued) begin
            fetch_error_held <= 1'b0;
        end else if (ev.fetch_error) begin
            fetch_error_held <= 1'b1;
        end
    end

    // =======================================================================
    // Address capture
    // =======================================================================
    // The imprecise and fetch errors carry no address, so only the precise
    // error loads the bus address, with the address the instruction asked for.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            bus_fault_address <= `RST_ADDR;
        end else if (ev.precise_data) begin
            bus_fault_address <= ev.data_addr;
        end else if (wr_bus_addr) begin
            bus_fault_address <= req.wdata;
        end
    end

    // The memory address takes the piece of a split access that faulted.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            memory_fault_address <= `RST_ADDR;
        end else if (ev.mem_fault) begin
            memory_fault_address <= ev.mem_addr;
        end else if (wr_mem_addr) begin
            memory_fault_address <= req.wdata;
        end
    end

    // Control register with the two trap enables.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            config_control_reg <= `RST_CONFIG;
        end else if (wr_config) begin
            config_control_reg <= req.wdata & `MASK_CONFIG;
        end
    end

    // =======================================================================
    // Imprecise bus fault pending
    // =======================================================================
    // The imprecise error is asynchronous: it waits while execution runs at
    // a more urgent level (lower number) than the bus fault handler.
    wire may_activate = EXEC_PRIORITY > BUS_FAULT_PRIORITY;
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            imprecise_pending <= 1'b0;
            BUS_FAULT_ACTIVATE <= 1'b0;
        end else begin
            if (ev.imprecise_data) begin
                imprecise_pending <= 1'b1;
            end else if (BUS_FAULT_TAKEN) begin
                imprecise_pending <= 1'b0;
            end
            BUS_FAULT_ACTIVATE <= imprecise_pending && may_activate && !BUS_FAULT_TAKEN;
        end
    end

    // =======================================================================
    // Read path
    // =======================================================================
    logic [31:0] read_mux;
    always_comb begin
        unique case (req.addr)
            `OFS_COMBINED_FLAGS: read_mux = combined_fault_flags;
            `OFS_HARD_FLAGS: read_mux = hard_fault_flags;
            `OFS_MEM_ADDR: read_mux = memory_fault_address;
            `OFS_BUS_ADDR: read_mux = bus_fault_address;
            `OFS_CONFIG_CTRL: read_mux = config_control_reg;
            `OFS_PENDING: read_mux = {31'h0000_0000, imprecise_pending};
            default: read_mux = 32'h0000_0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            REG_RDATA <= 32'h0000_0000;
            ZERO_DIVIDE_TRAP_EN <= 1'b0;
            MISALIGN_TRAP_EN <= 1'b0;
        end else begin
            REG_RDATA <= req.rd ? read_mux : 32'h0000_0000;
            ZERO_DIVIDE_TRAP_EN <= zero_div_trap;
            MISALIGN_TRAP_EN <= misalign_trap;
        end
    end

endmodule : fault_status_capture
`default_nettype wire

// ### tb/fault_status_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "fault_status_params.svh"
// ============================================================
// Port-level checker for the fault status block.
module fault_status_checker
    import fault_status_pkg::*;
(
    // Clock and reset.
    input wire logic MCLK,
    input wire logic SRST,
    // Core side.
    input wire fault_event_type FAULT_EVENT,
    input wire logic [7:0] EXEC_PRIORITY,
    input wire logic [7:0] BUS_FAULT_PRIORITY,
    input wire logic BUS_FAULT_TAKEN,
    // Register port.
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    // Status outputs.
    input wire logic BUS_FAULT_ACTIVATE,
    input wire logic ZERO_DIVIDE_TRAP_EN,
    input wire logic MISALIGN_TRAP_EN
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    // Read data stands for one cycle only, so a stale word never leaks into a later slot.
    idle_rdata_zero_a: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
        else $error("read data not zero outside read slot");
    unmapped_read_a: assert property (REG_RD && REG_ADDR > 8'h14 |=> REG_RDATA == 32'h0)
        else $error("unmapped read not zero");
    combined_rsvd_a: assert property (REG_RD && REG_ADDR == `OFS_COMBINED_FLAGS
        |=> (REG_RDATA & ~`MASK_COMBINED) == 32'h0)
        else $error("reserved combined bit set");
    hard_rsvd_a: assert property (REG_RD && REG_ADDR == `OFS_HARD_FLAGS
        |=> (REG_RDATA & ~32'h4000_0002) == 32'h0)
        else $error("reserved hard fault bit set");
    activate_cause_a: assert property (BUS_FAULT_ACTIVATE
        |-> $past(EXEC_PRIORITY) > $past(BUS_FAULT_PRIORITY))
        else $error("bus fault activated at blocking priority");
    activate_follow_a: assert property (FAULT_EVENT.imprecise_data &&
        EXEC_PRIORITY > BUS_FAULT_PRIORITY ##1 $stable(EXEC_PRIORITY) &&
        $stable(BUS_FAULT_PRIORITY) && !BUS_FAULT_TAKEN |=> BUS_FAULT_ACTIVATE)
        else $error("imprecise fault not activated");
    zero_trap_copy_a: assert property (REG_WR && REG_ADDR == `OFS_CONFIG_CTRL ##1
        !(REG_WR && REG_ADDR == `OFS_CONFIG_CTRL)
        |=> ZERO_DIVIDE_TRAP_EN == $past(REG_WDATA[`POS_ZERO_DIV_TRAP], 2))
        else $error("zero divide trap enable wrong");
    misalign_copy_a: assert property (REG_WR && REG_ADDR == `OFS_CONFIG_CTRL ##1
        !(REG_WR && REG_ADDR == `OFS_CONFIG_CTRL)
        |=> MISALIGN_TRAP_EN == $past(REG_WDATA[`POS_MISALIGN_TRAP], 2))
        else $error("misalign trap enable wrong");
endmodule : fault_status_checker

bind fault_status_capture fault_status_checker chk_u (
    .MCLK(MCLK), .SRST(SRST), .FAULT_EVENT(FAULT_EVENT), .EXEC_PRIORITY(EXEC_PRIORITY),
    .BUS_FAULT_PRIORITY(BUS_FAULT_PRIORITY), .BUS_FAULT_TAKEN(BUS_FAULT_TAKEN),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .BUS_FAULT_ACTIVATE(BUS_FAULT_ACTIVATE),
    .ZERO_DIVIDE_TRAP_EN(ZERO_DIVIDE_TRAP_EN), .MISALIGN_TRAP_EN(MISALIGN_TRAP_EN)
);
`default_nettype wire

// ### tb/fault_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Core-side event source with a prefetch-to-issue gap.
module fault_core_model
    import fault_status_pkg::*;
#(
    parameter int ISSUE_DELAY = 3
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Requests from the bench.
    input wire fault_event_type req,
    input wire logic go,
    input wire logic flush,
    // Events towards the block.
    output fault_event_type ev
);
    logic [3:0] cnt;
    // A flushed instruction never issues, so its prefetch error must stay hidden.
    always_ff @(posedge clk) begin
        if (rst) begin
            ev <= '0;
            cnt <= 4'h0;
        end else begin
            ev <= go ? req : '0;
            if (go && req.fetch_error) begin
                cnt <= 4'(ISSUE_DELAY);
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end
            if (cnt == 4'h1 && !flush) begin
                ev.fetch_issued <= 1'b1;
            end
        end
    end
endmodule : fault_core_model
`default_nettype wire

// ### tb/tb_fault_status_capture.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench for the fault status block.
module tb_fault_status_capture;
    import fault_status_pkg::*;
    logic MCLK = 1'b0;
    logic SRST = 1'b1;
    logic [7:0] exec_pri = 8'h10;
    logic [7:0] bus_pri = 8'h20;
    logic taken = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic go = 1'b0;
    logic flush = 1'b0;
    fault_event_type req = '0;
    fault_event_type ev;
    fault_event_type e;
    logic [31:0] rdata, a_val, acc_c, acc_h;
    logic act, zen, men;
    logic rd_d = 1'b0;
    logic [31:0] exp_q[$];
    logic [7:0] adr_q[$];
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;
    int k_tab[7] = '{10, 9, 8, 7, 6, 11, 12};
    int b_tab[7] = '{16, 17, 18, 19, 24, 30, 1};

    fault_core_model core_u (.clk(MCLK), .rst(SRST), .req(req), .go(go), .flush(flush), .ev(ev));
    fault_status_capture dut_u (
        .MCLK(MCLK), .SRST(SRST), .FAULT_EVENT(ev), .EXEC_PRIORITY(exec_pri),
        .BUS_FAULT_PRIORITY(bus_pri), .BUS_FAULT_TAKEN(taken), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .BUS_FAULT_ACTIVATE(act), .ZERO_DIVIDE_TRAP_EN(zen), .MISALIGN_TRAP_EN(men)
    );

    // Free-running 125 MHz clock.
    initial begin
        forever #4 MCLK = ~MCLK;
    end

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    // One aligned word access per cycle; strobes are left as set, so back-to-back
    // accesses need no idle cycle between them.
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge MCLK);
    endtask : bus

    task automatic rd_exp(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        adr_q.push_back(a);
        bus(1'b0, 1'b1, a, 32'h0);
    endtask : rd_exp

    task automatic idle(input int n);
        bus(1'b0, 1'b0, 8'h00, 32'h0);
        repeat (n) @(posedge MCLK);
    endtask : idle

    function automatic fault_event_type ev1(input int k);
        fault_event_type f;
        f = '0;
        f[77 - k] = 1'b1;
        return f;
    endfunction : ev1

    task automatic fire(input fault_event_type f);
        req <= f;
        go <= 1'b1;
        bus(1'b0, 1'b0, 8'h00, 32'h0);
        go <= 1'b0;
        @(posedge MCLK);
    endtask : fire

    // Read data is judged in the cycle after its strobe; a hang is cut by the cycle ceiling.
    always @(posedge MCLK) begin
        cycles++;
        if (rd_d) begin
            check($sformatf("register %h", adr_q.pop_front()), rdata, exp_q.pop_front());
        end
        rd_d = rd;
        if (cycles == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // Main sequence.
    initial begin
        void'($urandom(32'h8070e403));
        repeat (20) @(posedge MCLK);
        SRST <= 1'b0;
        bus(1'b1, 1'b0, 8'h00, 32'hffff_ffff);
        bus(1'b1, 1'b0, 8'h44, 32'hffff_ffff);
        for (int i = 0; i < 8; i++) rd_exp(8'(i * 4), 32'h0);
        $display("Test reset values done");
        acc_c = 32'h0;
        acc_h = 32'h0;
        for (int i = 0; i < 7; i++) begin
            fire(ev1(k_tab[i]));
            if (i < 5) acc_c[b_tab[i]] = 1'b1;
            else acc_h[b_tab[i]] = 1'b1;
            rd_exp(8'h00, acc_c);
            rd_exp(8'h04, acc_h);
        end
        bus(1'b1, 1'b0, 8'h00, 32'h0001_0000);
        rd_exp(8'h00, acc_c & 32'hfffe_ffff);
        bus(1'b1, 1'b0, 8'h04, 32'h8000_0000);
        rd_exp(8'h04, acc_h);
        bus(1'b1, 1'b0, 8'h04, 32'hc000_0002);
        rd_exp(8'h04, 32'h0);
        bus(1'b1, 1'b0, 8'h00, 32'hffff_ffff);
        e = ev1(10);
        e.bad_state = 1'b1;
        fire(e);
        rd_exp(8'h00, 32'h0001_0000);
        bus(1'b1, 1'b0, 8'h00, 32'hffff_ffff);
        $display("Test usage and hard flags done");
        fire(ev1(4));
        fire(ev1(5));
        rd_exp(8'h00, 32'h0);
        bus(1'b1, 1'b0, 8'h10, 32'h0000_0018);
        fire(ev1(4));
        fire(ev1(5));
        rd_exp(8'h00, 32'h0300_0000);
        check("trap enables", 32'({zen, men}), 32'h3);
        a_val = $urandom();
        bus(1'b1, 1'b0, 8'h00, 32'hffff_ffff);
        bus(1'b1, 1'b0, 8'h10, a_val);
        rd_exp(8'h10, a_val & 32'h18);
        $display("Test traps done");
        a_val = $urandom();
        e = ev1(1);
        e.data_addr = a_val;
        fire(e);
        // A handler reads the address before its valid flag.
        rd_exp(8'h0c, a_val);
        rd_exp(8'h00, 32'h0000_8200);
        e = ev1(13);
        e.mem_addr = ~a_val;
        fire(e);
        rd_exp(8'h08, ~a_val);
        rd_exp(8'h00, 32'h0000_0280);
        e = ev1(0);
        e.data_addr = 32'h0000_1234;
        fire(e);
        rd_exp(8'h00, 32'h0000_0680);
        rd_exp(8'h0c, a_val);
        rd_exp(8'h14, 32'h1);
        idle(2);
        check("held activate", 32'(act), 32'h0);
        exec_pri <= 8'h40;
        idle(3);
        check("activate", 32'(act), 32'h1);
        taken <= 1'b1;
        @(posedge MCLK);
        taken <= 1'b0;
        idle(2);
        check("taken activate", 32'(act), 32'h0);
        bus(1'b1, 1'b0, 8'h00, 32'hffff_ffff);
        rd_exp(8'h14, 32'h0);
        // With execution already below the bus fault level, activation follows at once.
        fire(ev1(0));
        idle(1);
        check("direct activate", 32'(act), 32'h1);
        taken <= 1'b1;
        bus(1'b1, 1'b0, 8'h00, 32'hffff_ffff);
        taken <= 1'b0;
        $display("Test bus faults done");
        fire(ev1(2));
        rd_exp(8'h00, 32'h0);
        idle(6);
        rd_exp(8'h00, 32'h0000_0100);
        bus(1'b1, 1'b0, 8'h00, 32'hffff_ffff);
        flush <= 1'b1;
        fire(ev1(2));
        idle(6);
        rd_exp(8'h00, 32'h0);
        idle(1);
        SRST <= 1'b1;
        flush <= 1'b0;
        repeat (2) @(posedge MCLK);
        SRST <= 1'b0;
        rd_exp(8'h0c, 32'h0);
        idle(2);
        $display("Test fetch and reset done");
        print_verdict();
    end
endmodule : tb_fault_status_capture
`default_nettype wire
